// File: core/imtc_map.vh
// Register map, field positions, reset values and timing counts
`ifndef IMTC_MAP_VH
`define IMTC_MAP_VH

// Register byte offsets
`define IMTC_CON_OFS      6'h00
`define IMTC_TAR_OFS      6'h04
`define IMTC_ENA_OFS      6'h08
`define IMTC_DCMD_OFS     6'h0c
`define IMTC_STAT_OFS     6'h10
`define IMTC_SSH_OFS      6'h14
`define IMTC_SSL_OFS      6'h18
`define IMTC_FSH_OFS      6'h1c
`define IMTC_FSL_OFS      6'h20
`define IMTC_DMA_OFS      6'h24

// Controller config fields
`define IMTC_CON_MASTER   0
`define IMTC_CON_SPD_LO   1
`define IMTC_CON_SPD_HI   2
`define IMTC_CON_SLV10    3
`define IMTC_SPD_STD      2'h1
`define IMTC_CON_RST      4'h5

// Target address fields
`define IMTC_TAR_ADDR_HI  9
`define IMTC_TAR_GC_SB    10
`define IMTC_TAR_SPECIAL  11
`define IMTC_TAR_TEN      12
`define IMTC_TAR_RST      13'h0055

// Data/command word
`define IMTC_CMD_RD       8

// Status fields
`define IMTC_ST_ACT       0
`define IMTC_ST_TFNF      1
`define IMTC_ST_TFE       2
`define IMTC_ST_RFNE      3
`define IMTC_ST_RFF       4
`define IMTC_ST_MACT      5
`define IMTC_ST_NACK      6

// DMA handshake control fields
`define IMTC_DMA_RX       0
`define IMTC_DMA_TX       1

// SCL phase minimums and functional clock rate
`define IMTC_FCLK_MHZ     16
`define IMTC_SS_HIGH_NS   4000
`define IMTC_SS_LOW_NS    4700
`define IMTC_FS_HIGH_NS   600
`define IMTC_FS_LOW_NS    1300
`define IMTC_NS_CNT(ns)   ((ns * `IMTC_FCLK_MHZ + 999) / 1000)
`define IMTC_SSH_RST      16'h0040
`define IMTC_SSL_RST      16'h004c
`define IMTC_FSH_RST      16'h000a
`define IMTC_FSL_RST      16'h0015

`endif

// File: core/imtc_top.v
// Two-wire master transfer controller with Avalon-MM registers
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "imtc_map.vh"

module imtc_fifo #(
	parameter W  = 9,
	parameter D  = 4,
	parameter AW = 2
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire         clr,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0]   cnt_q;
	wire         push;
	wire         pop;

	assign in_ready  = (cnt_q != D[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem[rp_q];
	assign push      = in_valid & in_ready & ~clr;
	assign pop       = out_valid & out_ready & ~clr;

	always @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_q  <= {AW{1'b0}};
			rp_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (clr) begin
			wp_q  <= {AW{1'b0}};
			rp_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

module imtc_top #(
	parameter FIFO_D  = 4,
	parameter FIFO_AW = 2
) (
	input  wire        clk,
	input  wire        rst_b,
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire        scl_i,
	output wire        scl_o,
	output wire        scl_oe,
	input  wire        sda_i,
	output wire        sda_o,
	output wire        sda_oe,
	output wire        dma_tx_req,
	output wire        dma_rx_req
);
	localparam S_IDLE  = 6'h01;
	localparam S_START = 6'h02;
	localparam S_LOAD  = 6'h04;
	localparam S_BIT   = 6'h08;
	localparam S_RST   = 6'h10;
	localparam S_STOP  = 6'h20;
	localparam H1  = 2'h0;
	localparam H2  = 2'h1;
	localparam H3  = 2'h2;
	localparam DAT = 2'h3;

	// Byte-enable merge of a write into a stored word
	function [31:0] be_merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  be;
		integer i;
		begin
			be_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i]) begin
					be_merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	// Phase count reached; a zero limit acts as one
	function done_f;
		input [15:0] c;
		input [15:0] lim;
		begin
			done_f = ({1'b0, c} + 17'h00001) >= {1'b0, lim};
		end
	endfunction

	reg [3:0]  con_q;
	reg [12:0] tar_q;
	reg        en_q;
	reg [15:0] ssh_q;
	reg [15:0] ssl_q;
	reg [15:0] fsh_q;
	reg [15:0] fsl_q;
	reg [1:0]  dma_q;
	reg        ack_q;
	reg [31:0] rdata_q;
	reg [31:0] rdata_d;
	reg        scl_m_q;
	reg        scl_s;
	reg        sda_m_q;
	reg        sda_s;
	reg [5:0]  st_q;
	reg [1:0]  sub_q;
	reg        ph_q;
	reg [15:0] cnt_q;
	reg [8:0]  sh_q;
	reg [7:0]  rsh_q;
	reg [3:0]  bc_q;
	reg [1:0]  stg_q;
	reg        rd_q;
	reg        isd_q;
	reg        rs_pend_q;
	reg        scl_low_q;
	reg        sda_low_q;
	reg        nack_q;
	reg [7:0]  hdr_byte;
	wire       req;
	wire       stall;
	wire       go_acc;
	wire       is_dcmd;
	wire       tx_in_rdy;
	wire       tx_v;
	wire [8:0] tx_dout;
	wire       rx_v;
	wire       rx_in_rdy;
	wire [7:0] rx_dout;
	wire       tx_push;
	wire       tx_pop;
	wire       rx_pop;
	wire       rx_push;
	wire       nack_flush;
	wire       hi_end;
	wire       std_mode;
	wire [15:0] hcnt;
	wire [15:0] lcnt;
	wire       is_stop;
	wire [31:0] wtmp;
	wire [31:0] con_m;
	wire [31:0] tar_m;
	wire [31:0] ssh_m;
	wire [31:0] ssl_m;
	wire [31:0] fsh_m;
	wire [31:0] fsl_m;

	// Bus slave handshake; a full command FIFO holds the write off
	assign is_dcmd  = (avs_address[5:2] == `IMTC_DCMD_OFS >> 2);
	assign req      = avs_read | avs_write;
	assign stall    = avs_write & is_dcmd & en_q & ~tx_in_rdy;
	assign go_acc   = req & ~ack_q & ~stall;
	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata    = rdata_q;
	assign tx_push  = go_acc & avs_write & is_dcmd & en_q;
	assign rx_pop   = go_acc & avs_read & is_dcmd & rx_v;

	// Byte-lane merges of the write data into the config, target and count registers
	assign wtmp  = be_merge(32'h00000000, avs_writedata, avs_byteenable);
	assign con_m = be_merge({28'h0000000, con_q}, wtmp, avs_byteenable);
	assign tar_m = be_merge({19'h00000, tar_q}, wtmp, avs_byteenable);
	assign ssh_m = be_merge({16'h0000, ssh_q}, wtmp, avs_byteenable);
	assign ssl_m = be_merge({16'h0000, ssl_q}, wtmp, avs_byteenable);
	assign fsh_m = be_merge({16'h0000, fsh_q}, wtmp, avs_byteenable);
	assign fsl_m = be_merge({16'h0000, fsl_q}, wtmp, avs_byteenable);

	always @* begin
		rdata_d = 32'h00000000;
		case ({avs_address[5:2], 2'b00})
			`IMTC_CON_OFS:  rdata_d[3:0] = con_q;
			`IMTC_TAR_OFS:  rdata_d[12:0] = tar_q;
			`IMTC_ENA_OFS:  rdata_d[0] = en_q;
			`IMTC_DCMD_OFS: rdata_d[7:0] = rx_v ? rx_dout : 8'h00;
			`IMTC_STAT_OFS: begin
				rdata_d[`IMTC_ST_ACT]  = (st_q != S_IDLE) | tx_v;
				rdata_d[`IMTC_ST_TFNF] = tx_in_rdy;
				rdata_d[`IMTC_ST_TFE]  = ~tx_v;
				rdata_d[`IMTC_ST_RFNE] = rx_v;
				rdata_d[`IMTC_ST_RFF]  = ~rx_in_rdy;
				rdata_d[`IMTC_ST_MACT] = (st_q != S_IDLE);
				rdata_d[`IMTC_ST_NACK] = nack_q;
			end
			`IMTC_SSH_OFS:  rdata_d[15:0] = ssh_q;
			`IMTC_SSL_OFS:  rdata_d[15:0] = ssl_q;
			`IMTC_FSH_OFS:  rdata_d[15:0] = fsh_q;
			`IMTC_FSL_OFS:  rdata_d[15:0] = fsl_q;
			`IMTC_DMA_OFS:  rdata_d[1:0] = dma_q;
			default:        rdata_d = 32'h00000000;
		endcase
	end

	// Register writes and read capture
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			con_q   <= `IMTC_CON_RST;
			tar_q   <= `IMTC_TAR_RST;
			en_q    <= 1'b0;
			ssh_q   <= `IMTC_SSH_RST;
			ssl_q   <= `IMTC_SSL_RST;
			fsh_q   <= `IMTC_FSH_RST;
			fsl_q   <= `IMTC_FSL_RST;
			dma_q   <= 2'h0;
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q <= go_acc;
			if (go_acc & avs_read) begin
				rdata_q <= rdata_d;
			end
			if (go_acc & avs_write) begin
				case ({avs_address[5:2], 2'b00})
					`IMTC_CON_OFS: con_q <= con_m[3:0];
					`IMTC_TAR_OFS: tar_q <= tar_m[12:0];
					`IMTC_ENA_OFS: if (avs_byteenable[0]) en_q <= wtmp[0];
					`IMTC_SSH_OFS: ssh_q <= ssh_m[15:0];
					`IMTC_SSL_OFS: ssl_q <= ssl_m[15:0];
					`IMTC_FSH_OFS: fsh_q <= fsh_m[15:0];
					`IMTC_FSL_OFS: fsl_q <= fsl_m[15:0];
					`IMTC_DMA_OFS: if (avs_byteenable[0]) dma_q <= wtmp[1:0];
					default: ;
				endcase
			end
		end
	end

	// Command and receive buffers, cleared while disabled
	imtc_fifo #(.W(9), .D(FIFO_D), .AW(FIFO_AW)) u_txf (
		.clk       (clk),
		.rst_b     (rst_b),
		.clr       (~en_q | nack_flush),
		.in_valid  (tx_push),
		.in_ready  (tx_in_rdy),
		.in_data   (avs_writedata[8:0]),
		.out_valid (tx_v),
		.out_ready (tx_pop),
		.out_data  (tx_dout)
	);

	imtc_fifo #(.W(8), .D(FIFO_D), .AW(FIFO_AW)) u_rxf (
		.clk       (clk),
		.rst_b     (rst_b),
		.clr       (~en_q),
		.in_valid  (rx_push),
		.in_ready  (rx_in_rdy),
		.in_data   (rsh_q),
		.out_valid (rx_v),
		.out_ready (rx_pop),
		.out_data  (rx_dout)
	);

	assign dma_tx_req = dma_q[`IMTC_DMA_TX] & en_q & tx_in_rdy;
	assign dma_rx_req = dma_q[`IMTC_DMA_RX] & rx_v;

	// Pin synchronisers
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_m_q <= 1'b1;
			scl_s   <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s   <= 1'b1;
		end else begin
			scl_m_q <= scl_i;
			scl_s   <= scl_m_q;
			sda_m_q <= sda_i;
			sda_s   <= sda_m_q;
		end
	end

	assign std_mode = (con_q[`IMTC_CON_SPD_HI:`IMTC_CON_SPD_LO] == `IMTC_SPD_STD);
	assign hcnt     = std_mode ? ssh_q : fsh_q;
	assign lcnt     = std_mode ? ssl_q : fsl_q;
	assign hi_end   = ph_q & scl_s & done_f(cnt_q, hcnt);
	assign is_stop  = (st_q == S_STOP);
	assign tx_pop   = (st_q == S_LOAD) & (stg_q == DAT) & ~rs_pend_q & tx_v &
		(tx_dout[`IMTC_CMD_RD] == rd_q) & (~rd_q | rx_in_rdy);
	assign rx_push  = (st_q == S_BIT) & hi_end & (bc_q == 4'h8) & isd_q & rd_q;
	assign nack_flush = (st_q == S_BIT) & hi_end & (bc_q == 4'h8) &
		~(isd_q & rd_q) & sda_s;

	// Address bytes for 7-bit, 10-bit and special targets
	always @* begin
		hdr_byte = 8'h00;
		case (stg_q)
			H1: begin
				if (tar_q[`IMTC_TAR_SPECIAL]) begin
					hdr_byte = tar_q[`IMTC_TAR_GC_SB] ? 8'h01 : 8'h00;
				end else if (tar_q[`IMTC_TAR_TEN]) begin
					hdr_byte = {5'h1e, tar_q[9:8], 1'b0};
				end else begin
					hdr_byte = {tar_q[6:0], rd_q};
				end
			end
			H2: hdr_byte = tar_q[7:0];
			H3: hdr_byte = {5'h1e, tar_q[9:8], 1'b1};
			default: hdr_byte = 8'h00;
		endcase
	end

	// Transfer engine
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q      <= S_IDLE;
			sub_q     <= 2'h0;
			ph_q      <= 1'b0;
			cnt_q     <= 16'h0000;
			sh_q      <= 9'h1ff;
			rsh_q     <= 8'h00;
			bc_q      <= 4'h0;
			stg_q     <= H1;
			rd_q      <= 1'b0;
			isd_q     <= 1'b0;
			rs_pend_q <= 1'b0;
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
			nack_q    <= 1'b0;
		end else begin
			case (st_q)
				S_IDLE: begin
					scl_low_q <= 1'b0;
					sda_low_q <= 1'b0;
					cnt_q     <= 16'h0000;
					sub_q     <= 2'h0;
					ph_q      <= 1'b1;
					if (en_q & con_q[`IMTC_CON_MASTER] & tx_v) begin
						rd_q   <= tx_dout[`IMTC_CMD_RD];
						stg_q  <= H1;
						nack_q <= 1'b0;
						st_q   <= S_START;
					end
				end
				S_START: begin
					if (scl_s) begin
						cnt_q <= cnt_q + 16'h0001;
					end
					if (hi_end) begin
						cnt_q <= 16'h0000;
						if (sub_q == 2'h0) begin
							sda_low_q <= 1'b1;
							sub_q     <= 2'h1;
						end else begin
							scl_low_q <= 1'b1;
							st_q      <= S_LOAD;
						end
					end
				end
				S_LOAD: begin
					cnt_q <= 16'h0000;
					ph_q  <= 1'b0;
					bc_q  <= 4'h0;
					sub_q <= 2'h0;
					if (rs_pend_q) begin
						rs_pend_q <= 1'b0;
						st_q      <= S_RST;
					end else if (stg_q != DAT) begin
						sh_q  <= {hdr_byte, 1'b1};
						isd_q <= 1'b0;
						st_q  <= S_BIT;
						if (stg_q == H1 & tar_q[`IMTC_TAR_TEN] &
								~tar_q[`IMTC_TAR_SPECIAL]) begin
							stg_q <= H2;
						end else if (stg_q == H2 & rd_q) begin
							stg_q     <= H3;
							rs_pend_q <= 1'b1;
						end else begin
							stg_q <= DAT;
						end
					end else if (!tx_v) begin
						st_q <= S_STOP;
					end else if (tx_dout[`IMTC_CMD_RD] != rd_q) begin
						rd_q  <= tx_dout[`IMTC_CMD_RD];
						stg_q <= H1;
						st_q  <= S_RST;
					end else if (tx_pop) begin
						sh_q  <= rd_q ? 9'h1ff : {tx_dout[7:0], 1'b1};
						isd_q <= 1'b1;
						st_q  <= S_BIT;
					end
				end
				S_BIT: begin
					if (!ph_q) begin
						scl_low_q <= 1'b1;
						if (bc_q == 4'h8 && isd_q && rd_q) begin
							sda_low_q <= tx_v & tx_dout[`IMTC_CMD_RD];
						end else begin
							sda_low_q <= ~sh_q[8];
						end
						cnt_q <= cnt_q + 16'h0001;
						if (done_f(cnt_q, lcnt)) begin
							cnt_q     <= 16'h0000;
							ph_q      <= 1'b1;
							scl_low_q <= 1'b0;
						end
					end else begin
						if (scl_s) begin
							cnt_q <= cnt_q + 16'h0001;
						end
						if (hi_end) begin
							cnt_q     <= 16'h0000;
							ph_q      <= 1'b0;
							scl_low_q <= 1'b1;
							sh_q      <= {sh_q[7:0], 1'b1};
							bc_q      <= bc_q + 4'h1;
							if (bc_q != 4'h8) begin
								rsh_q <= {rsh_q[6:0], sda_s};
							end else if (nack_flush) begin
								nack_q <= 1'b1;
								sub_q  <= 2'h0;
								st_q   <= S_STOP;
							end else begin
								st_q <= S_LOAD;
							end
						end
					end
				end
				S_RST, S_STOP: begin
					if (sub_q == 2'h0) begin
						scl_low_q <= 1'b1;
						sda_low_q <= is_stop;
						cnt_q     <= cnt_q + 16'h0001;
						if (done_f(cnt_q, lcnt)) begin
							cnt_q     <= 16'h0000;
							scl_low_q <= 1'b0;
							ph_q      <= 1'b1;
							sub_q     <= 2'h1;
						end
					end else begin
						if (scl_s) begin
							cnt_q <= cnt_q + 16'h0001;
						end
						if (hi_end) begin
							cnt_q <= 16'h0000;
							if (sub_q == 2'h1) begin
								sda_low_q <= ~is_stop;
								sub_q     <= 2'h2;
							end else if (is_stop) begin
								st_q <= S_IDLE;
							end else begin
								scl_low_q <= 1'b1;
								st_q      <= S_LOAD;
							end
						end
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	assign scl_o  = 1'b0;
	assign sda_o  = 1'b0;
	assign scl_oe = scl_low_q;
	assign sda_oe = sda_low_q;
endmodule

// File: tb/imtc_slave_model.sv
// Behavioural remote slave on the two-wire bus
`timescale 1ns/1ps
module imtc_slave_model #(
	parameter [6:0] ADDR    = 7'h55,
	parameter [7:0] RD_BYTE = 8'h3c
) (
	input  wire       scl,
	input  wire       sda,
	output reg        sda_pull,
	output reg  [7:0] last_wr
);
	reg [7:0] sh = 8'h0;
	reg       hdr = 1'b0;
	reg       rd = 1'b0;
	reg       on = 1'b0;
	integer   n = 0;
	initial begin
		sda_pull = 1'b0;
		last_wr = 8'h0;
	end
	// Start or repeated start opens an address phase
	always @(negedge sda) if (scl === 1'b1) begin
		{hdr, rd, on} = 3'b101;
		n = 0;
	end
	always @(posedge sda) if (scl === 1'b1) on = 1'b0;
	always @(posedge scl) if (on) begin
		if (n < 8) sh = {sh[6:0], sda};
		if (n == 8 && rd && !hdr && sda) on = 1'b0;
		n = n + 1;
	end
	always @(negedge scl) if (on) begin
		if (n == 9) begin
			n = 0;
			hdr = 1'b0;
		end
		if (n == 8 && hdr) rd = sh[0];
		if (n == 8 && !hdr && !rd) last_wr = sh;
		if (n == 8) sda_pull = hdr ? sh[7:1] == ADDR : !rd;
		else sda_pull = rd && !hdr && !RD_BYTE[7 - n];
		if (n == 8 && hdr && sh[7:1] != ADDR) on = 1'b0;
	end
endmodule

// File: tb/imtc_top_checker.sv
// Port assertions for the two-wire master controller
`timescale 1ns/1ps
module imtc_top_checker (
	input wire        clk,
	input wire        rst_b,
	input wire [5:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire        scl_oe,
	input wire        sda_oe
);
	// Std counts the bench programs
	localparam int MIN_HI = 64;
	localparam int MIN_LO = 76;
	reg [15:0] hi_q;
	reg [15:0] lo_q;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_q <= 16'h0;
			lo_q <= 16'h0;
		end else begin
			hi_q <= scl_oe ? 16'h0 : hi_q + 16'h1;
			lo_q <= scl_oe ? lo_q + 16'h1 : 16'h0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	idle_no_wait_a: assert property (
		!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest without request");
	read_answer_a: assert property (
		$rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read not answered in one cycle");
	write_answer_a: assert property (
		$rose(avs_write) && avs_address != 6'h0c
		|-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("write not answered in one cycle");
	rdata_hold_a: assert property (
		!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data moved without a read");
	scl_high_min_a: assert property (
		$rose(scl_oe) |-> hi_q >= MIN_HI)
		else $error("clock high phase short");
	scl_low_min_a: assert property (
		$fell(scl_oe) |-> lo_q >= MIN_LO)
		else $error("clock low phase short");
	start_hold_a: assert property (
		$rose(sda_oe) && !scl_oe |-> (!scl_oe)[*8])
		else $error("clock pulled too soon after start");
	stop_free_a: assert property (
		$fell(sda_oe) && !scl_oe && !$past(scl_oe) |-> (!scl_oe)[*8])
		else $error("bus not left free after stop");
endmodule

bind imtc_top imtc_top_checker chk (.clk(clk), .rst_b(rst_b),
	.avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .scl_oe(scl_oe), .sda_oe(sda_oe));

// File: tb/imtc_top_tb.sv
// Self-checking bench for the two-wire master controller
`timescale 1ns/1ps
`include "imtc_map.vh"
module imtc_top_tb;
	reg         clk = 1'b0;
	reg         rst_b = 1'b0;
	reg  [5:0]  avs_address = 6'h0;
	reg         avs_read = 1'b0;
	reg         avs_write = 1'b0;
	reg  [31:0] avs_writedata = 32'h0;
	reg  [31:0] q;
	reg  [5:0]  a;
	wire [31:0] avs_readdata;
	wire [7:0]  last_wr;
	wire        avs_waitrequest, scl_oe, sda_oe, s_pull, dma_tx_req, dma_rx_req;
	wire        scl_w = ~scl_oe;
	wire        sda_w = ~(sda_oe | s_pull);
	integer     failures = 0, tests_run = 0, starts = 0, stops = 0, i;
	always #25 clk = ~clk;
	always @(negedge sda_w) if (scl_w) starts = starts + 1;
	always @(posedge sda_w) if (scl_w) stops = stops + 1;
	imtc_top dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.scl_i(scl_w), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(),
		.sda_oe(sda_oe), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
	imtc_slave_model slave (.scl(scl_w), .sda(sda_w), .sda_pull(s_pull),
		.last_wr(last_wr));
	function [31:0] cnt(input integer k);
		integer ns;
		begin
			case (k)
				0: ns = `IMTC_SS_HIGH_NS;
				1: ns = `IMTC_SS_LOW_NS;
				2: ns = `IMTC_FS_HIGH_NS;
				default: ns = `IMTC_FS_LOW_NS;
			endcase
			cnt = (ns * `IMTC_FCLK_MHZ + 999) / 1000;
		end
	endfunction
	task check(input [95:0] nm, input [31:0] seen, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task acc(input rd, input [5:0] ad, input [31:0] d, output [31:0] r);
		integer k;
		begin
			@(posedge clk);
			avs_address <= ad;
			avs_writedata <= d;
			avs_read <= rd;
			avs_write <= !rd;
			k = 0;
			@(posedge clk);
			while (avs_waitrequest !== 1'b0 && k < 4000) begin
				@(posedge clk);
				k = k + 1;
			end
			if (k >= 4000) failures = failures + 1;
			r = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task wr(input [5:0] ad, input [31:0] d);
		acc(1'b0, ad, d, q);
	endtask
	task rchk(input [95:0] nm, input [5:0] ad, input [31:0] e);
		begin
			acc(1'b1, ad, 32'h0, q);
			check(nm, q, e);
		end
	endtask
	task idle;
		integer k;
		begin
			k = 0;
			do begin
				repeat (50) @(posedge clk);
				acc(1'b1, `IMTC_STAT_OFS, 32'h0, q);
				k = k + 1;
			end while ((q[5] !== 1'b0 || q[2] !== 1'b1) && k < 400);
			repeat (200) @(posedge clk);
			check("idle", k < 400, 32'h1);
		end
	endtask
	task final_report;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, failures);
			if (failures == 0 && tests_run > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		repeat (80000) @(posedge clk);
		failures = failures + 1;
		final_report;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		starts = 0;
		stops = 0;
		rchk("con", `IMTC_CON_OFS, `IMTC_CON_RST);
		rchk("tar", `IMTC_TAR_OFS, `IMTC_TAR_RST);
		rchk("dma", `IMTC_DMA_OFS, 32'h0);
		wr(6'h28, 32'hffffffff);
		rchk("unmapped", 6'h28, 32'h0);
		wr(`IMTC_ENA_OFS, 32'h0);
		wr(`IMTC_CON_OFS, 32'hf);
		rchk("con_wr", `IMTC_CON_OFS, 32'hf);
		wr(`IMTC_TAR_OFS, 32'h1fff);
		rchk("tar_wr", `IMTC_TAR_OFS, 32'h1fff);
		for (i = 0; i < 4; i = i + 1) begin
			a = `IMTC_SSH_OFS + 6'h4 * i[5:0];
			rchk("cnt_rst", a, cnt(i));
			wr(a, 32'hffff);
			rchk("cnt_wr", a, 32'hffff);
			wr(a, cnt(i));
		end
		wr(`IMTC_CON_OFS, 32'h3);
		wr(`IMTC_TAR_OFS, 32'h55);
		$display("test registers done");
		wr(`IMTC_DCMD_OFS, 32'h0a5);
		repeat (300) @(posedge clk);
		acc(1'b1, `IMTC_STAT_OFS, 32'h0, q);
		check("stat_off", q & 32'h2e, 32'h06);
		check("starts_off", starts, 0);
		$display("test disabled done");
		wr(`IMTC_ENA_OFS, 32'h1);
		wr(`IMTC_DCMD_OFS, 32'h0a5);
		wr(`IMTC_DCMD_OFS, 32'h05a);
		wr(`IMTC_DCMD_OFS, 32'h100);
		idle;
		check("starts", starts, 2);
		check("stops", stops, 1);
		check("wr_byte", last_wr, 8'h5a);
		check("stat", q & 32'h6c, 32'h0c);
		wr(`IMTC_DMA_OFS, 32'h1);
		check("rx_req", {dma_tx_req, dma_rx_req}, 2'b01);
		wr(`IMTC_DMA_OFS, 32'h2);
		check("tx_req", {dma_tx_req, dma_rx_req}, 2'b10);
		wr(`IMTC_DMA_OFS, 32'h0);
		rchk("rd_byte", `IMTC_DCMD_OFS, 32'h3c);
		$display("test mixed transfer done");
		wr(`IMTC_TAR_OFS, 32'h56);
		wr(`IMTC_DCMD_OFS, 32'h011);
		idle;
		check("nack", q & 32'h64, 32'h44);
		check("stops_nack", stops, 2);
		wr(`IMTC_TAR_OFS, 32'h1055);
		wr(`IMTC_DCMD_OFS, 32'h077);
		idle;
		check("ten_bit", q & 32'h64, 32'h44);
		check("ten_wr", last_wr, 8'h5a);
		check("stops_ten", stops, 3);
		wr(`IMTC_TAR_OFS, 32'h55);
		$display("test address update done");
		for (i = 1; i < 7; i = i + 1)
			wr(`IMTC_DCMD_OFS, 32'h11 * i);
		idle;
		check("burst_last", last_wr, 8'h66);
		check("stops_burst", stops, 4);
		check("nack_clr", q & 32'h40, 32'h0);
		$display("test fifo burst done");
		final_report;
	end
endmodule
